// File: hw/eamg_pkg.sv
package eamg_pkg;

  // Widths of the bus and of the power samples
  localparam int PWR_W = 24;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int IDX_W = 6;
  localparam int REG_W = 8;
  localparam int IRQ_W = 3;
  localparam int SEL_DATA_LANE = 0;

  // Register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ACCUMULATION_MODE = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_GAIN = 6'h1B;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h20;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h21;
  localparam logic [IDX_W-1:0] IDX_LIVE = 6'h22;

  // Highest gain code with a defined gain (16)
  localparam logic [2:0] GAIN_MAX_CODE = 3'h4;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [DAT_W-1:0] dat;
  } eamg_wb_req_t;

  // Layout of the accumulation-mode register, bit 7 down to bit 0
  typedef struct packed {
    logic tamper_current_select;
    logic fault_event_edge;
    logic reactive_sign_edge;
    logic active_sign_edge;
    logic reactive_absolute_accum;
    logic reactive_signed_by_active;
    logic active_positive_only;
    logic active_absolute_accum;
  } eamg_acc_mode_t;

  // Layout of the channel gain register, bit 7 down to bit 0
  typedef struct packed {
    logic [2:0] voltage_gain_sel;
    logic reserved;
    logic sign_detect_source;
    logic [2:0] current_gain_sel;
  } eamg_gain_t;

  // Layout of interrupt status and mask, bit 2 down to bit 0
  typedef struct packed {
    logic fault;
    logic reactive;
    logic active;
  } eamg_irq_t;

  typedef struct packed {
    logic signed [PWR_W-1:0] active;
    logic signed [PWR_W-1:0] reactive;
  } eamg_power_t;

  typedef struct packed {
    eamg_power_t pwr;
    logic valid;
  } eamg_shape_st_t;

  typedef struct packed {
    eamg_acc_mode_t acc;
    eamg_gain_t gain;
    eamg_irq_t stat;
    eamg_irq_t mask;
    logic ack;
    logic [DAT_W-1:0] rdat;
    logic irq;
    logic act_seen;
    logic act_neg;
    logic rea_seen;
    logic rea_neg;
    logic fault_prev;
  } eamg_top_st_t;

  // Every register default is zero
  localparam eamg_top_st_t TOP_ST_RST = '0;
  localparam eamg_shape_st_t SHAPE_ST_RST = '0;

endpackage

// File: hw/eamg_accum_shape.sv
`timescale 1ns/1ps
module eamg_accum_shape import eamg_pkg::*; (
  input logic core_clk,
  input logic rst,
  input eamg_power_t sample,
  input logic sample_valid,
  input eamg_acc_mode_t mode,
  output eamg_power_t shaped,
  output logic shaped_valid
);

  eamg_shape_st_t s_r;
  eamg_shape_st_t s_nxt;

  always_comb begin
    logic signed [PWR_W-1:0] act;
    logic signed [PWR_W-1:0] rea;
    act = sample.active;
    rea = sample.reactive;
    s_nxt = s_r;
    s_nxt.valid = sample_valid;
    // Absolute wins over positive-only when both are set
    if (mode.active_absolute_accum && act < 0) begin
      act = -act;
    end else if (mode.active_positive_only && act < 0) begin
      act = '0;
    end
    if (mode.reactive_absolute_accum && rea < 0) begin
      rea = -rea;
    end else if (!mode.reactive_absolute_accum &&
                 mode.reactive_signed_by_active && sample.active < 0) begin
      rea = -rea;
    end
    // Most negative sample wraps on negation; front end never reaches it
    if (sample_valid) begin
      s_nxt.pwr.active = act;
      s_nxt.pwr.reactive = rea;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= SHAPE_ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign shaped = s_r.pwr;
  assign shaped_valid = s_r.valid;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_act_abs_value: assert property (
    (sample_valid && mode.active_absolute_accum) |=>
      shaped.active == ($past(sample.active) < 0 ?
                        -$past(sample.active) : $past(sample.active)))
    else $error("active absolute accumulation wrong");

  a_act_pos_only: assert property (
    (sample_valid && !mode.active_absolute_accum &&
     mode.active_positive_only && sample.active < 0) |=>
      shaped.active == 0 && shaped_valid)
    else $error("negative active power not discarded");

  a_rea_abs_value: assert property (
    (sample_valid && mode.reactive_absolute_accum) |=>
      shaped.reactive == ($past(sample.reactive) < 0 ?
                          -$past(sample.reactive) : $past(sample.reactive)))
    else $error("reactive absolute accumulation wrong");

  a_rea_by_active: assert property (
    (sample_valid && !mode.reactive_absolute_accum &&
     mode.reactive_signed_by_active) |=>
      shaped.reactive == ($past(sample.active) < 0 ?
                          -$past(sample.reactive) : $past(sample.reactive)))
    else $error("reactive sign not steered by active power");

endmodule

// File: hw/eamg_top.sv
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
module eamg_top import eamg_pkg::*; (
  input logic core_clk,
  input logic rst,

  input eamg_wb_req_t wb_req,
  output logic [DAT_W-1:0] wb_dat_r,
  output logic wb_ack,

  input eamg_power_t power_in,
  input logic power_valid,
  input logic active_cf_pulse,
  input logic reactive_cf_pulse,
  input logic fault_mode,
  input logic tamper_chan_b,

  output eamg_power_t shaped_power,
  output logic shaped_valid,
  output logic [2:0] voltage_gain_sel,
  output logic [2:0] current_gain_sel,
  output logic sign_detect_source,
  output logic irq
);

  eamg_top_st_t st_r;
  eamg_top_st_t st_nxt;

  logic take;
  logic wr;
  logic [IDX_W-1:0] idx;
  logic act_stb;
  logic rea_stb;
  logic act_now_neg;
  logic rea_now_neg;
  eamg_irq_t ev;
  eamg_irq_t clr;

  // Sign change of the wanted direction, ignoring the very first sample
  function automatic logic sign_event(
    input logic seen,
    input logic prev_neg,
    input logic now_neg,
    input logic edge_sel
  );
    return seen && (prev_neg != now_neg) && (now_neg != edge_sel);
  endfunction

  function automatic logic gain_ok(input logic [2:0] code);
    return code <= GAIN_MAX_CODE;
  endfunction

  function automatic logic is_reg(
    input logic [IDX_W-1:0] a,
    input logic [IDX_W-1:0] r
  );
    return a == r;
  endfunction

  assign take = wb_req.cyc && wb_req.stb && !st_r.ack;
  assign idx = wb_req.adr[ADR_W-1:2];
  // Registers live in byte lane 0; other lanes alone write nothing
  assign wr = take && wb_req.we && wb_req.sel[SEL_DATA_LANE];

  // Sign source follows the detect-source bit
  assign act_stb = st_r.gain.sign_detect_source ?
                   active_cf_pulse : power_valid;
  assign rea_stb = st_r.gain.sign_detect_source ?
                   reactive_cf_pulse : power_valid;
  assign act_now_neg = power_in.active[PWR_W-1];
  assign rea_now_neg = power_in.reactive[PWR_W-1];

  always_comb begin
    ev.active = act_stb && sign_event(st_r.act_seen, st_r.act_neg,
      act_now_neg, st_r.acc.active_sign_edge);
    ev.reactive = rea_stb && sign_event(st_r.rea_seen, st_r.rea_neg,
      rea_now_neg, st_r.acc.reactive_sign_edge);
    // Edge bit 0 fires on entering fault, 1 on returning to normal
    ev.fault = (fault_mode != st_r.fault_prev) &&
               (fault_mode != st_r.acc.fault_event_edge);
  end

  always_comb begin
    clr = '0;
    if (wr && is_reg(idx, IDX_IRQ_STAT)) begin
      clr = eamg_irq_t'(wb_req.dat[IRQ_W-1:0]);
    end
  end

  always_comb begin
    eamg_gain_t gw;
    gw = eamg_gain_t'(wb_req.dat[REG_W-1:0]);
    st_nxt = st_r;
    st_nxt.ack = take;
    st_nxt.rdat = '0;

    // Channel in use is live state, never written by software
    st_nxt.acc.tamper_current_select = tamper_chan_b;

    if (wr && is_reg(idx, IDX_ACCUMULATION_MODE)) begin
      st_nxt.acc = eamg_acc_mode_t'({tamper_chan_b,
                                     wb_req.dat[REG_W-2:0]});
    end

    if (wr && is_reg(idx, IDX_GAIN)) begin
      // Undefined codes leave the old gain in place
      if (gain_ok(gw.voltage_gain_sel)) begin
        st_nxt.gain.voltage_gain_sel = gw.voltage_gain_sel;
      end
      if (gain_ok(gw.current_gain_sel)) begin
        st_nxt.gain.current_gain_sel = gw.current_gain_sel;
      end
      st_nxt.gain.sign_detect_source = gw.sign_detect_source;
      st_nxt.gain.reserved = 1'b0;
    end

    if (wr && is_reg(idx, IDX_IRQ_MASK)) begin
      st_nxt.mask = eamg_irq_t'(wb_req.dat[IRQ_W-1:0]);
    end

    // A new event in the clearing cycle survives the clear
    st_nxt.stat = (st_r.stat & ~clr) | ev;
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

    if (act_stb) begin
      st_nxt.act_seen = 1'b1;
      st_nxt.act_neg = act_now_neg;
    end
    if (rea_stb) begin
      st_nxt.rea_seen = 1'b1;
      st_nxt.rea_neg = rea_now_neg;
    end
    st_nxt.fault_prev = fault_mode;

    // Unmapped indexes read zero and still acknowledge
    if (take && !wb_req.we) begin
      case (idx)
        IDX_ACCUMULATION_MODE: st_nxt.rdat[REG_W-1:0] = st_r.acc;
        IDX_GAIN: st_nxt.rdat[REG_W-1:0] = st_r.gain;
        IDX_IRQ_STAT: st_nxt.rdat[IRQ_W-1:0] = st_r.stat;
        IDX_IRQ_MASK: st_nxt.rdat[IRQ_W-1:0] = st_r.mask;
        IDX_LIVE: st_nxt.rdat[4:0] = {st_r.fault_prev,
                                      st_r.rea_seen, st_r.rea_neg,
                                      st_r.act_seen, st_r.act_neg};
        default: st_nxt.rdat = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= TOP_ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  eamg_accum_shape u_shape (
    .core_clk(core_clk),
    .rst(rst),
    .sample(power_in),
    .sample_valid(power_valid),
    .mode(st_r.acc),
    .shaped(shaped_power),
    .shaped_valid(shaped_valid)
  );

  assign wb_dat_r = st_r.rdat;
  assign wb_ack = st_r.ack;
  assign irq = st_r.irq;
  assign voltage_gain_sel = st_r.gain.voltage_gain_sel;
  assign current_gain_sel = st_r.gain.current_gain_sel;
  assign sign_detect_source = st_r.gain.sign_detect_source;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_ack_one_cycle: assert property (
    (wb_req.cyc && wb_req.stb && !wb_ack) |=> wb_ack ##1 !wb_ack)
    else $error("ack not a single cycle after request");

  a_tamper_read: assert property (
    (take && !wb_req.we && idx == IDX_ACCUMULATION_MODE) |=>
      wb_dat_r[REG_W-1] == $past(tamper_chan_b, 2))
    else $error("tamper channel bit not reported");

  a_fault_enter: assert property (
    ($rose(fault_mode) && !st_r.acc.fault_event_edge) |=> st_r.stat.fault)
    else $error("fault entry did not flag");

  a_fault_quiet: assert property (
    ($fell(fault_mode) && !st_r.acc.fault_event_edge &&
     !$past(st_r.stat.fault) && !st_r.stat.fault) |=> !st_r.stat.fault)
    else $error("return to normal flagged in entry mode");

  a_rea_edge_hit: assert property (
    (rea_stb && st_r.rea_seen && !st_r.rea_neg && rea_now_neg &&
     !st_r.acc.reactive_sign_edge) |=> st_r.stat.reactive)
    else $error("reactive positive to negative missed");

  a_act_edge_hit: assert property (
    (act_stb && st_r.act_seen && st_r.act_neg && !act_now_neg &&
     st_r.acc.active_sign_edge) ##1 st_r.mask.active |-> irq)
    else $error("active negative to positive missed");

  a_act_edge_miss: assert property (
    (!st_r.stat.active && act_stb && st_r.act_seen &&
     !st_r.act_neg && act_now_neg && st_r.acc.active_sign_edge) |=>
      !st_r.stat.active)
    else $error("active flag on the unselected edge");

  a_source_pulse: assert property (
    (st_r.gain.sign_detect_source && !active_cf_pulse && power_valid) |=>
      $stable(st_r.act_neg))
    else $error("filtered sample used in pulse mode");

  a_gain_write: assert property (
    (wr && idx == IDX_GAIN && wb_req.dat[7:5] <= GAIN_MAX_CODE) |=>
      voltage_gain_sel == $past(wb_req.dat[7:5]))
    else $error("voltage gain not written");

  a_gain_current: assert property (
    (wr && idx == IDX_GAIN && wb_req.dat[2:0] <= GAIN_MAX_CODE) |=>
      current_gain_sel == $past(wb_req.dat[2:0]))
    else $error("current gain not written");

  a_gain_range: assert property (
    (wr && idx == IDX_GAIN && wb_req.dat[2:0] > GAIN_MAX_CODE) |=>
      $stable(current_gain_sel))
    else $error("undefined gain code accepted");

  a_rsvd_zero: assert property (
    (take && !wb_req.we && idx == IDX_GAIN) |=> !wb_dat_r[4])
    else $error("reserved gain bit not zero");

  a_flag_set_wins: assert property (
    (ev.active && wr && idx == IDX_IRQ_STAT && wb_req.dat[0]) |=>
      st_r.stat.active [*2])
    else $error("event lost under clear");

  a_stat_clear: assert property (
    (wr && idx == IDX_IRQ_STAT && wb_req.dat[0] && !ev.active) |=>
      !st_r.stat.active)
    else $error("active flag not cleared by write");

  a_irq_level: assert property (
    irq == |(st_r.stat & st_r.mask))
    else $error("irq does not follow unmasked flags");

  a_mask_write: assert property (
    (wr && idx == IDX_IRQ_MASK) |=>
      st_r.mask == $past(wb_req.dat[IRQ_W-1:0]))
    else $error("mask not written");

  a_acc_write: assert property (
    (wr && idx == IDX_ACCUMULATION_MODE) |=>
      st_r.acc[REG_W-2:0] == $past(wb_req.dat[REG_W-2:0]))
    else $error("mode bits not written");

  a_tamper_live: assert property (
    st_r.acc.tamper_current_select == $past(tamper_chan_b))
    else $error("tamper channel copy stale");

  a_rdat_idle: assert property (
    !wb_ack |-> wb_dat_r == '0)
    else $error("read data not zero outside ack");

  a_fault_exit: assert property (
    ($fell(fault_mode) && st_r.acc.fault_event_edge) |=> st_r.stat.fault)
    else $error("return to normal did not flag");

  a_rea_edge_miss: assert property (
    (!st_r.stat.reactive && rea_stb && st_r.rea_seen &&
     st_r.rea_neg && !rea_now_neg &&
     !st_r.acc.reactive_sign_edge) |=> !st_r.stat.reactive)
    else $error("reactive flag on the unselected edge");

  a_act_edge_fall: assert property (
    (act_stb && st_r.act_seen && !st_r.act_neg && act_now_neg &&
     !st_r.acc.active_sign_edge) |=> st_r.stat.active)
    else $error("active positive to negative missed");

  a_gain_vrange: assert property (
    (wr && idx == IDX_GAIN && wb_req.dat[7:5] > GAIN_MAX_CODE) |=>
      $stable(voltage_gain_sel))
    else $error("undefined voltage gain code accepted");

  a_source_rea: assert property (
    (st_r.gain.sign_detect_source && !reactive_cf_pulse && power_valid) |=>
      $stable(st_r.rea_neg))
    else $error("filtered sample used in reactive pulse mode");

  a_source_filter: assert property (
    (!st_r.gain.sign_detect_source && active_cf_pulse && !power_valid) |=>
      $stable(st_r.act_neg))
    else $error("energy pulse used in filtered mode");

endmodule

// File: test/eamg_tb.sv
`timescale 1ns/1ps
module tb import eamg_pkg::*;;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  eamg_wb_req_t wb_req = '0;
  logic [DAT_W-1:0] wb_dat_r;
  logic wb_ack;
  eamg_power_t power_in = '0;
  eamg_power_t shaped_power;
  logic power_valid = 1'b0;
  logic active_cf_pulse = 1'b0;
  logic reactive_cf_pulse = 1'b0;
  logic fault_mode = 1'b0;
  logic tamper_chan_b = 1'b0;
  logic shaped_valid, sign_detect_source, irq;
  logic [2:0] voltage_gain_sel, current_gain_sel;
  int n_fail = 0;
  int check_count = 0;
  // Reference model state
  logic [7:0] m_acc = '0;
  logic [7:0] m_gain = '0;
  logic [2:0] m_stat = '0;
  logic [2:0] m_mask = '0;
  bit m_aseen, m_aneg, m_rseen, m_rneg, m_fprev;

  always #25 core_clk = ~core_clk;

  eamg_top uut (.core_clk(core_clk), .rst(rst), .wb_req(wb_req),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .power_in(power_in),
    .power_valid(power_valid), .active_cf_pulse(active_cf_pulse),
    .reactive_cf_pulse(reactive_cf_pulse), .fault_mode(fault_mode),
    .tamper_chan_b(tamper_chan_b), .shaped_power(shaped_power),
    .shaped_valid(shaped_valid), .voltage_gain_sel(voltage_gain_sel),
    .current_gain_sel(current_gain_sel),
    .sign_detect_source(sign_detect_source), .irq(irq));

  task automatic chk(input string nm, input logic [47:0] e, g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Abs wins over the weaker mode bit; negation wraps like hardware
  function automatic logic [47:0] shp(input logic [7:0] m,
      input logic signed [23:0] a, r);
    logic signed [23:0] ea, er;
    ea = a;
    er = r;
    if (m[0]) ea = (a < 0) ? -a : a;
    else if (m[1] && a < 0) ea = '0;
    if (m[3]) er = (r < 0) ? -r : r;
    else if (m[2] && a < 0) er = -r;
    return {ea, er};
  endfunction

  task automatic bus(input logic we, input logic [7:0] adr,
      input logic [31:0] d, input logic [3:0] sel, output logic [31:0] rd);
    int i;
    i = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: d};
    do begin
      @(posedge core_clk);
      i++;
    end while (wb_ack !== 1'b1 && i < 20);
    if (wb_ack !== 1'b1) begin
      chk("wb_ack", 48'h1, {47'h0, wb_ack});
      close_out;
    end
    rd = wb_dat_r;
    wb_req <= '0;
    // One idle cycle so the next request never lands in this step
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d,
      input logic [3:0] sel);
    logic [31:0] x;
    bus(1'b1, adr, {24'h0, d}, sel, x);
    if (sel[0]) case (adr)
      8'h3C: m_acc[6:0] = d[6:0];
      8'h6C: begin
        if (d[7:5] <= GAIN_MAX_CODE) m_gain[7:5] = d[7:5];
        m_gain[3] = d[3];
        if (d[2:0] <= GAIN_MAX_CODE) m_gain[2:0] = d[2:0];
      end
      8'h80: m_stat = m_stat & ~d[2:0];
      8'h84: m_mask = d[2:0];
    endcase
  endtask

  task automatic rdm(input logic [7:0] adr);
    logic [31:0] d, e;
    case (adr)
      8'h3C: e = {24'h0, tamper_chan_b, m_acc[6:0]};
      8'h6C: e = {24'h0, m_gain};
      8'h80: e = {29'h0, m_stat};
      8'h84: e = {29'h0, m_mask};
      8'h88: e = {27'h0, m_fprev, m_rseen, m_rneg, m_aseen, m_aneg};
      default: e = '0;
    endcase
    bus(1'b0, adr, '0, 4'hF, d);
    chk($sformatf("read %h", adr), e, d);
    chk("irq", |(m_stat & m_mask), irq);
  endtask

  task automatic upd(input bit s, n, ed, inout bit seen, pn, input int b);
    if (s) begin
      if (seen && pn != n && n == !ed) m_stat[b] = 1'b1;
      seen = 1'b1;
      pn = n;
    end
  endtask

  task automatic step(input logic signed [23:0] a, r, input bit pv, ap, rp);
    logic [47:0] e;
    power_in <= {a, r};
    power_valid <= pv;
    active_cf_pulse <= ap;
    reactive_cf_pulse <= rp;
    @(posedge core_clk);
    power_valid <= 1'b0;
    active_cf_pulse <= 1'b0;
    reactive_cf_pulse <= 1'b0;
    e = shp(m_acc, a, r);
    upd(m_gain[3] ? ap : pv, a[23], m_acc[4], m_aseen, m_aneg, 0);
    upd(m_gain[3] ? rp : pv, r[23], m_acc[5], m_rseen, m_rneg, 1);
    @(posedge core_clk);
    chk("shaped_valid", pv, shaped_valid);
    if (pv) chk("shaped_power", e, shaped_power);
    @(posedge core_clk);
    chk("irq", |(m_stat & m_mask), irq);
  endtask

  task automatic flt(input bit v);
    fault_mode <= v;
    @(posedge core_clk);
    if (v != m_fprev && v == !m_acc[6]) m_stat[2] = 1'b1;
    m_fprev = v;
    repeat (3) @(posedge core_clk);
  endtask

  initial begin
    void'($urandom(32'hBFEDB5FC));
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdm(8'h3C);
    rdm(8'h6C);
    rdm(8'h80);
    chk("gain ports", '0, {voltage_gain_sel, current_gain_sel});
    // Voltage codes climb while current codes fall, so both hit 5..7
    for (int c = 0; c < 8; c++) begin
      wr(8'h6C, {c[2:0], 1'b1, c[0], 3'(7 - c)}, 4'hF);
      rdm(8'h6C);
      chk("voltage_gain_sel", m_gain[7:5], voltage_gain_sel);
      chk("current_gain_sel", m_gain[2:0], current_gain_sel);
      chk("sign_detect_source", m_gain[3], sign_detect_source);
    end
    wr(8'h6C, 8'h00, 4'hE);
    rdm(8'h6C);
    wr(8'h40, 8'hFF, 4'hF);
    rdm(8'h40);
    wr(8'h6C, 8'h00, 4'hF);
    tamper_chan_b <= 1'b1;
    wr(8'h3C, 8'h00, 4'hF);
    rdm(8'h3C);
    tamper_chan_b <= 1'b0;
    wr(8'h3C, 8'h80, 4'hF);
    rdm(8'h3C);
    for (int m = 0; m < 16; m++) begin
      wr(8'h3C, 8'(m), 4'hF);
      step(-24'sd5, 24'sd9, 1'b1, 1'b0, 1'b0);
      repeat (4) step($urandom, $urandom, 1'b1, 1'b0, 1'b0);
    end
    wr(8'h84, 8'h07, 4'hF);
    for (int e = 0; e < 2; e++) begin
      wr(8'h3C, {1'b0, e[0], e[0], e[0], 4'h0}, 4'hF);
      wr(8'h80, 8'h07, 4'hF);
      step(24'sd3, 24'sd3, 1'b1, 1'b0, 1'b0);
      step(-24'sd3, -24'sd3, 1'b1, 1'b0, 1'b0);
      rdm(8'h80);
      step(24'sd3, 24'sd0, 1'b1, 1'b0, 1'b0);
      flt(1'b1);
      rdm(8'h80);
      flt(1'b0);
      rdm(8'h80);
    end
    wr(8'h84, 8'h00, 4'hF);
    rdm(8'h80);
    wr(8'h84, 8'h05, 4'hF);
    wr(8'h80, 8'h01, 4'hF);
    rdm(8'h80);
    // Sign event lands in the very cycle its flag is cleared
    step(-24'sd3, -24'sd3, 1'b1, 1'b0, 1'b0);
    power_in <= {24'sd3, 24'sd3};
    power_valid <= 1'b1;
    fork
      wr(8'h80, 8'h03, 4'hF);
      begin
        @(posedge core_clk);
        power_valid <= 1'b0;
      end
    join
    upd(1'b1, 1'b0, m_acc[4], m_aseen, m_aneg, 0);
    upd(1'b1, 1'b0, m_acc[5], m_rseen, m_rneg, 1);
    rdm(8'h80);
    wr(8'h6C, 8'h08, 4'hF);
    repeat (24) step($urandom, $urandom, $urandom, $urandom, $urandom);
    rdm(8'h80);
    rdm(8'h88);
    close_out;
  end
endmodule
